// ===== shared/rx_dma_pkg.sv
// constants and types shared by the receive dma device and its controller
package rx_dma_pkg;
   // device register indices, reached over the device's own port
   localparam logic [2:0]  IDX_MBS_LOW    = 3'h0;
   localparam logic [2:0]  IDX_MBS_HIGH   = 3'h1;
   localparam logic [2:0]  IDX_BC_LOW     = 3'h2;
   localparam logic [2:0]  IDX_BC_HIGH    = 3'h3;
   localparam logic [2:0]  IDX_CFG3_HIGH  = 3'h4;
   localparam logic [2:0]  IDX_IRQ_STATUS = 3'h5;
   localparam logic [2:0]  IDX_IRQ_MASK   = 3'h6;
   // field positions
   localparam int          POS_ENABLE_CMD = 7;
   localparam int          POS_LIMIT_DIS  = 6;
   localparam int          SIZE_HIGH_W    = 6;
   localparam int          POS_THRESHOLD  = 0;
   localparam int          POS_RBF        = 0;
   localparam int          POS_RX_TRANSFER_END_IRQ       = 1;
   // reset values
   localparam logic [7:0]  RST_MBS_LOW    = 8'hff;
   localparam logic [7:0]  RST_MBS_HIGH   = 8'h00;
   localparam logic [7:0]  RST_CFG3_HIGH  = 8'h00;
   localparam logic [7:0]  RST_IRQ_MASK   = 8'h00;
   // sizes
   localparam int          BLOCK_BYTES    = 32;
   localparam int          FIFO_DEPTH     = 64;
   // controller apb offsets and command/status field positions
   localparam logic [7:0]  OFS_DEV_CMD    = 8'h00;
   localparam logic [7:0]  OFS_DEV_DATA   = 8'h04;
   localparam logic [7:0]  OFS_DMA_BASE   = 8'h08;
   localparam logic [7:0]  OFS_DMA_COUNT  = 8'h0c;
   localparam logic [7:0]  OFS_STATUS     = 8'h10;
   localparam int          POS_CMD_DATA   = 8;
   localparam int          POS_CMD_WRITE  = 16;
   localparam int          POS_ST_REQ     = 0;
   localparam int          POS_ST_IRQ     = 1;

   typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_BLOCK} dev_state_t;
endpackage

// ===== shared/rx_dma_if.sv
// link between the receive dma device and the external dma controller
`timescale 1ns/10ps
`default_nettype none
interface rx_dma_if;
   logic       reg_wr;
   logic [2:0] reg_addr;
   logic [7:0] reg_wdata;
   logic [7:0] reg_rdata;
   logic       dma_req;
   logic       dma_ack;
   logic [7:0] dma_data;
   logic       irq;

   modport device (
      input  reg_wr,
      input  reg_addr,
      input  reg_wdata,
      input  dma_ack,
      output reg_rdata,
      output dma_req,
      output dma_data,
      output irq
   );

   modport controller (
      output reg_wr,
      output reg_addr,
      output reg_wdata,
      output dma_ack,
      input  reg_rdata,
      input  dma_req,
      input  dma_data,
      input  irq
   );
endinterface
`default_nettype wire

// ===== hdl/rx_dma_device.sv
// receive dma support logic: receive fifo, block requests, buffer limit
`timescale 1ns/10ps
`default_nettype none
module rx_dma_device
   import rx_dma_pkg::*;
#(
   parameter int DEPTH = FIFO_DEPTH,
   parameter int BLOCK = BLOCK_BYTES
)
(
   input  wire logic       i_clk,
   input  wire logic       i_rst,
   input  wire logic       i_ce,
   rx_dma_if.device        link,
   input  wire logic       i_rx_valid,
   input  wire logic [7:0] i_rx_data,
   input  wire logic       i_rx_last,
   output var  logic       o_rx_ready
);
   localparam int AW = $clog2(DEPTH);
   localparam int BW = $clog2(BLOCK) + 1;
   localparam int SW = SIZE_HIGH_W + 8;

   logic [8:0]      mem [DEPTH];
   logic [AW-1:0]   wr_ptr;
   logic [AW-1:0]   rd_ptr;
   logic [AW:0]     level;
   logic [AW:0]     next_level;
   logic [AW:0]     eop_count;
   logic [7:0]      mbs_low;
   logic [6:0]      mbs_high;
   logic [1:0]      threshold;
   logic [7:0]      irq_status;
   logic [7:0]      irq_mask;
   logic [15:0]     byte_count;
   logic [15:0]     pkt_bytes;
   logic [SW-1:0]   tally;
   logic [SW-1:0]   max_size;
   logic [BW-1:0]   block_left;
   logic [BW-1:0]   block_size;
   dev_state_t      state;
   logic            push;
   logic            pop;
   logic            pop_last;
   logic            limit_on;
   logic            limit_hit;
   logic            enable_cmd;
   logic            start_block;
   logic            block_done;
   logic [7:0]      irq_set;
   logic [7:0]      irq_clr;

   assign push       = i_rx_valid & o_rx_ready;
   assign pop        = link.dma_ack & link.dma_req;
   assign pop_last   = pop & mem[rd_ptr][8];
   assign max_size   = {mbs_high[SIZE_HIGH_W-1:0], mbs_low};
   assign limit_on   = ~mbs_high[POS_LIMIT_DIS];
   assign limit_hit  = pop & limit_on & ((tally + SW'(1)) >= max_size);
   assign enable_cmd = link.reg_wr & (link.reg_addr == IDX_MBS_HIGH) & link.reg_wdata[POS_ENABLE_CMD];
   assign block_size = BW'(BLOCK >> threshold);
   assign block_done = pop & (block_left == BW'(1));
   assign start_block = (state == ST_WAIT) & ~enable_cmd
                        & ((level >= (AW+1)'(block_size)) | (eop_count != '0))
                        & (~limit_on | (tally < max_size));
   assign next_level = level + (AW+1)'(push) - (AW+1)'(pop);

   // receive fifo, one status flag per byte marks packet end
   always_ff @(posedge i_clk)
   begin
      if (i_ce && push)
      begin
         mem[wr_ptr] <= {i_rx_last, i_rx_data};
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         wr_ptr     <= '0;
         rd_ptr     <= '0;
         level      <= '0;
         eop_count  <= '0;
         o_rx_ready <= 1'b0;
      end
      else if (i_ce)
      begin
         if (push)
         begin
            wr_ptr <= wr_ptr + AW'(1);
         end
         if (pop)
         begin
            rd_ptr <= rd_ptr + AW'(1);
         end
         level      <= next_level;
         eop_count  <= eop_count + (AW+1)'(push & i_rx_last) - (AW+1)'(pop_last);
         o_rx_ready <= (next_level != (AW+1)'(DEPTH));
      end
   end

   // fifo head, refreshed every cycle; acks must be spaced two cycles apart
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         link.dma_data <= 8'h00;
      end
      else if (i_ce)
      begin
         link.dma_data <= mem[rd_ptr][7:0];
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         state        <= ST_IDLE;
         link.dma_req <= 1'b0;
         block_left   <= '0;
      end
      else if (i_ce)
      begin
         case (state)
            ST_IDLE:
            begin
               if (enable_cmd)
               begin
                  state <= ST_WAIT;
               end
            end
            ST_WAIT:
            begin
               if (start_block)
               begin
                  state        <= ST_BLOCK;
                  link.dma_req <= 1'b1;
                  block_left   <= block_size;
               end
            end
            ST_BLOCK:
            begin
               if (pop)
               begin
                  block_left <= block_left - BW'(1);
               end
               if (pop_last | limit_hit)
               begin
                  state        <= enable_cmd ? ST_WAIT : ST_IDLE;
                  link.dma_req <= 1'b0;
               end
               else if (block_done)
               begin
                  state        <= ST_WAIT;
                  link.dma_req <= 1'b0;
               end
            end
            default:
            begin
               state        <= ST_IDLE;
               link.dma_req <= 1'b0;
            end
         endcase
      end
   end

   // transferred byte tally and per-packet byte count
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         tally      <= '0;
         pkt_bytes  <= '0;
         byte_count <= '0;
      end
      else if (i_ce)
      begin
         if (enable_cmd)
         begin
            tally <= '0;
         end
         else if (pop)
         begin
            tally <= tally + SW'(1);
         end
         if (pop_last)
         begin
            byte_count <= pkt_bytes + 16'h0001;
            pkt_bytes  <= '0;
         end
         else if (pop)
         begin
            pkt_bytes <= pkt_bytes + 16'h0001;
         end
      end
   end

   // configuration registers
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         mbs_low   <= RST_MBS_LOW;
         mbs_high  <= RST_MBS_HIGH[6:0];
         threshold <= RST_CFG3_HIGH[POS_THRESHOLD +: 2];
         irq_mask  <= RST_IRQ_MASK;
      end
      else if (i_ce && link.reg_wr)
      begin
         case (link.reg_addr)
            IDX_MBS_LOW:   mbs_low   <= link.reg_wdata;
            IDX_MBS_HIGH:  mbs_high  <= link.reg_wdata[6:0];
            IDX_CFG3_HIGH: threshold <= link.reg_wdata[POS_THRESHOLD +: 2];
            IDX_IRQ_MASK:  irq_mask  <= link.reg_wdata;
            default:       mbs_low   <= mbs_low;
         endcase
      end
   end

   always_comb
   begin
      irq_set           = 8'h00;
      irq_set[POS_RBF]  = limit_hit;
      irq_set[POS_RX_TRANSFER_END_IRQ] = pop_last;
      irq_clr           = 8'h00;
      if (link.reg_wr && (link.reg_addr == IDX_IRQ_STATUS))
      begin
         irq_clr = link.reg_wdata;
      end
   end

   // sticky events; a set in the clearing cycle survives
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         irq_status <= 8'h00;
         link.irq   <= 1'b0;
      end
      else if (i_ce)
      begin
         irq_status <= (irq_status & ~irq_clr) | irq_set;
         link.irq   <= |(irq_status & irq_mask);
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         link.reg_rdata <= 8'h00;
      end
      else if (i_ce)
      begin
         case (link.reg_addr)
            IDX_MBS_LOW:    link.reg_rdata <= mbs_low;
            IDX_MBS_HIGH:   link.reg_rdata <= {state != ST_IDLE, mbs_high};
            IDX_BC_LOW:     link.reg_rdata <= byte_count[7:0];
            IDX_BC_HIGH:    link.reg_rdata <= byte_count[15:8];
            IDX_CFG3_HIGH:  link.reg_rdata <= {6'h00, threshold};
            IDX_IRQ_STATUS: link.reg_rdata <= irq_status;
            IDX_IRQ_MASK:   link.reg_rdata <= irq_mask;
            default:        link.reg_rdata <= 8'h00;
         endcase
      end
   end
endmodule
`default_nettype wire

// ===== hdl/rx_dma_controller.sv
// external dma controller with apb command registers for the cpu
`timescale 1ns/10ps
`default_nettype none
module rx_dma_controller
   import rx_dma_pkg::*;
(
   input  wire logic        i_clk,
   input  wire logic        i_rst,
   input  wire logic        i_ce,
   input  wire logic        i_psel,
   input  wire logic        i_penable,
   input  wire logic        i_pwrite,
   input  wire logic [31:0] i_paddr,
   input  wire logic [31:0] i_pwdata,
   output var  logic [31:0] o_prdata,
   output var  logic        o_pready,
   output var  logic        o_pslverr,
   rx_dma_if.controller     link,
   output var  logic        o_mem_we,
   output var  logic [31:0] o_mem_addr,
   output var  logic [7:0]  o_mem_data,
   output var  logic        o_irq
);
   logic [31:0] base;
   logic [31:0] count;
   logic [7:0]  dev_data;
   logic        setup;
   logic        apb_wr;
   logic        hit;
   logic [7:0]  ofs;

   assign ofs    = i_paddr[7:0];
   assign setup  = i_psel & ~i_penable & ~o_pready;
   assign apb_wr = i_psel & i_penable & o_pready & i_pwrite;
   assign hit    = (ofs == OFS_DEV_CMD) | (ofs == OFS_DEV_DATA) | (ofs == OFS_DMA_BASE)
                   | (ofs == OFS_DMA_COUNT) | (ofs == OFS_STATUS);

   // one wait-free access: ready rises in the access phase
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         o_pready  <= 1'b0;
         o_pslverr <= 1'b0;
         o_prdata  <= 32'h00000000;
      end
      else if (i_ce)
      begin
         o_pready  <= setup;
         o_pslverr <= setup & ~hit;
         if (setup)
         begin
            case (ofs)
               OFS_DEV_DATA:  o_prdata <= {24'h000000, dev_data};
               OFS_DMA_BASE:  o_prdata <= base;
               OFS_DMA_COUNT: o_prdata <= count;
               OFS_STATUS:    o_prdata <= {30'h00000000, link.irq, link.dma_req};
               default:       o_prdata <= 32'h00000000;
            endcase
         end
      end
   end

   // device register access; read data follows the selected index
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         link.reg_wr    <= 1'b0;
         link.reg_addr  <= 3'h0;
         link.reg_wdata <= 8'h00;
         dev_data       <= 8'h00;
         o_irq          <= 1'b0;
      end
      else if (i_ce)
      begin
         link.reg_wr <= 1'b0;
         if (apb_wr && (ofs == OFS_DEV_CMD))
         begin
            link.reg_addr  <= i_pwdata[2:0];
            link.reg_wdata <= i_pwdata[POS_CMD_DATA +: 8];
            link.reg_wr    <= i_pwdata[POS_CMD_WRITE];
         end
         dev_data <= link.reg_rdata;
         o_irq    <= link.irq;
      end
   end

   // byte mover: ack never in two cycles running so dma_data has refreshed to the fifo head at each pop
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         link.dma_ack <= 1'b0;
         base         <= 32'h00000000;
         count        <= 32'h00000000;
         o_mem_we     <= 1'b0;
         o_mem_addr   <= 32'h00000000;
         o_mem_data   <= 8'h00;
      end
      else if (i_ce)
      begin
         link.dma_ack <= link.dma_req & ~link.dma_ack;
         o_mem_we     <= link.dma_req & link.dma_ack;
         if (link.dma_req && link.dma_ack)
         begin
            o_mem_addr <= base + count;
            o_mem_data <= link.dma_data;
         end
         if (apb_wr && (ofs == OFS_DMA_BASE))
         begin
            base  <= i_pwdata;
            count <= 32'h00000000;
         end
         else if (link.dma_req && link.dma_ack)
         begin
            count <= count + 32'h00000001;
         end
      end
   end
endmodule
`default_nettype wire

// ===== testbench/rx_dma_assertions.sv
// interface checker for the receive dma link
`timescale 1ns/10ps
`default_nettype none
module rx_dma_assertions
   import rx_dma_pkg::*;
(
   input wire logic       i_clk,
   input wire logic       i_rst,
   input wire logic       reg_wr,
   input wire logic [2:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic       dma_req,
   input wire logic       dma_ack,
   input wire logic [7:0] dma_data,
   input wire logic       irq
);
   logic [7:0]  lo;
   logic [7:0]  hi;
   logic [7:0]  mask;
   logic [1:0]  thr;
   logic [15:0] tally;
   logic [15:0] burst;
   logic [15:0] lim;
   logic        pop;
   logic        dis;
   assign pop = dma_req & dma_ack;
   assign dis = hi[POS_LIMIT_DIS];
   assign lim = {2'h0, hi[5:0], lo};
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_rst);
   always_ff @(posedge i_clk)
      if (i_rst)
      begin
         lo   <= RST_MBS_LOW;
         hi   <= RST_MBS_HIGH;
         mask <= RST_IRQ_MASK;
         thr  <= RST_CFG3_HIGH[1:0];
      end
      else if (reg_wr)
         case (reg_addr)
            IDX_MBS_LOW:   lo <= reg_wdata;
            IDX_MBS_HIGH:  hi <= reg_wdata;
            IDX_IRQ_MASK:  mask <= reg_wdata;
            IDX_CFG3_HIGH: thr <= reg_wdata[1:0];
            default: ;
         endcase
   // the enable command restarts the tally, as the device does
   always_ff @(posedge i_clk)
      if (i_rst || (reg_wr && reg_addr == IDX_MBS_HIGH && reg_wdata[POS_ENABLE_CMD]))
         tally <= 16'h0000;
      else if (pop)
         tally <= tally + 16'h0001;
   always_ff @(posedge i_clk)
      if (i_rst || !dma_req)
         burst <= 16'h0000;
      else if (pop)
         burst <= burst + 16'h0001;
   ack_single_a: assert property (dma_ack |=> !dma_ack)
      else $error("ack in two consecutive cycles");
   ack_req_a: assert property (dma_ack |-> dma_req)
      else $error("ack without request");
   block_size_a: assert property (burst <= (16'(BLOCK_BYTES) >> thr))
      else $error("block longer than threshold allows");
   limit_cap_a: assert property (pop && !dis |-> tally < lim)
      else $error("pop beyond buffer size");
   limit_stop_a: assert property (!dis && tally >= lim |-> !dma_req)
      else $error("request at buffer limit");
   rbf_irq_a: assert property (pop && !dis && mask[POS_RBF] && tally + 16'h1 == lim |=> ##1 irq)
      else $error("no interrupt at buffer full");
   clear_irq_a: assert property (reg_wr && reg_addr == IDX_IRQ_STATUS && reg_wdata[1:0] == 2'b11
      && !dma_ack ##1 !dma_ack |=> !irq) else $error("interrupt not cleared");
   size_readback_a: assert property (reg_wr && reg_addr == IDX_MBS_LOW ##1
      !reg_wr && reg_addr == IDX_MBS_LOW |=> reg_rdata == lo) else $error("size not applied");
   cover property (pop && burst == 16'(BLOCK_BYTES) - 16'h1);
   cover property (pop && !dis && tally + 16'h1 == lim);
   cover property ($rose(irq));
endmodule
`default_nettype wire

// ===== testbench/receive_dma_support_logic_test.sv
// self-checking bench for the receive dma device and controller
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin num_errors++; \
   $display("Error %s expected %h seen %h", n, e, g); end end
module receive_dma_support_logic_test
   import rx_dma_pkg::*;
;
   logic        i_clk;
   logic        i_rst;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [31:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        e;
   logic        rx_valid;
   logic [7:0]  rx_data;
   logic        rx_last;
   logic        rx_ready;
   logic        mem_we;
   logic [31:0] mem_addr;
   logic [7:0]  mem_data;
   logic        irq;
   logic [7:0]  seq;
   logic [7:0]  m;
   logic [31:0] r;
   logic [31:0] exp_addr;
   logic [7:0]  exp_q[$];
   int          num_errors;
   int          compares;
   logic [2:0]  ri[5] = '{IDX_MBS_LOW, IDX_MBS_HIGH, IDX_CFG3_HIGH, IDX_IRQ_MASK, 3'h7};
   logic [7:0]  rv[5] = '{RST_MBS_LOW, RST_MBS_HIGH, RST_CFG3_HIGH, RST_IRQ_MASK, 8'h00};
   rx_dma_if    link();
   rx_dma_device u_rx_dma_device (.i_clk(i_clk), .i_rst(i_rst), .i_ce(1'b1), .link(link),
      .i_rx_valid(rx_valid), .i_rx_data(rx_data), .i_rx_last(rx_last), .o_rx_ready(rx_ready));
   rx_dma_controller u_rx_dma_controller (.i_clk(i_clk), .i_rst(i_rst), .i_ce(1'b1), .i_psel(psel),
      .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
      .o_pready(pready), .o_pslverr(pslverr), .link(link), .o_mem_we(mem_we), .o_mem_addr(mem_addr),
      .o_mem_data(mem_data), .o_irq(irq));
   rx_dma_assertions u_rx_dma_assertions (.i_clk(i_clk), .i_rst(i_rst), .reg_wr(link.reg_wr),
      .reg_addr(link.reg_addr), .reg_wdata(link.reg_wdata), .reg_rdata(link.reg_rdata),
      .dma_req(link.dma_req), .dma_ack(link.dma_ack), .dma_data(link.dma_data), .irq(link.irq));
   initial
   begin
      i_clk = 1'b0;
      forever #50 i_clk = ~i_clk;
   end
   task automatic results();
      $display("compares %0d errors %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // starts on an edge of its own so psel is never assigned twice in one step
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge i_clk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, 24'h0, a, d};
      @(posedge i_clk);
      penable <= 1'b1;
      do
         @(posedge i_clk);
      while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      {psel, penable} <= 2'b00;
   endtask
   task automatic dw(input logic [2:0] i, input logic [7:0] d);
      apb(1'b1, OFS_DEV_CMD, {15'h0, 1'b1, d, 5'h0, i});
   endtask
   task automatic dr(input logic [2:0] i);
      apb(1'b1, OFS_DEV_CMD, {29'h0, i});
      repeat (3) @(posedge i_clk);
      apb(1'b0, OFS_DEV_DATA, 32'h0);
   endtask
   task automatic send(input int n);
      @(posedge i_clk);
      for (int i = 0; i < n; i++)
      begin
         {rx_valid, rx_data, rx_last} <= {1'b1, seq, i == n - 1};
         exp_q.push_back(seq);
         seq = seq + 8'h01;
         do
            @(posedge i_clk);
         while (rx_ready !== 1'b1);
      end
      {rx_valid, rx_last} <= 2'b00;
   endtask
   // controller irq lags a status clear by a few cycles
   task automatic wait_irq();
      int n;
      n = 0;
      repeat (4) @(posedge i_clk);
      while (irq !== 1'b1 && n++ < 3000)
         @(posedge i_clk);
      `CHK("irq", 1'b1, irq)
   endtask
   always @(posedge i_clk)
      if (mem_we === 1'b1)
      begin
         m = exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx;
         `CHK("mem_data", m, mem_data)
         `CHK("mem_addr", exp_addr, mem_addr)
         exp_addr = exp_addr + 32'h00000001;
      end
   initial
   begin
      repeat (30000) @(posedge i_clk);
      num_errors++;
      results();
   end
   initial
   begin
      {psel, penable, pwrite, rx_valid, rx_last, paddr, pwdata, rx_data, seq} = '0;
      {i_rst, num_errors, compares} = {1'b1, 64'h0};
      repeat (16) @(posedge i_clk);
      i_rst <= 1'b0;
      for (int i = 0; i < 5; i++)
      begin
         dr(ri[i]);
         `CHK("reset value", rv[i], r[7:0])
      end
      apb(1'b0, 8'h14, 32'h0);
      `CHK("unmapped", 1'b1, e)
      dw(IDX_IRQ_MASK, 8'h03);
      apb(1'b1, OFS_DMA_BASE, 32'h100);
      exp_addr = 32'h00000100;
      dw(IDX_MBS_LOW, 8'd40);
      dw(IDX_MBS_HIGH, 8'h80);
      send(50);
      wait_irq();
      repeat (20) @(posedge i_clk);
      dr(IDX_IRQ_STATUS);
      `CHK("full flag", 8'h01, r[7:0])
      apb(1'b0, OFS_DMA_COUNT, 32'h0);
      `CHK("count at limit", 32'd40, r)
      dw(IDX_IRQ_STATUS, 8'h03);
      apb(1'b1, OFS_DMA_BASE, 32'h200);
      exp_addr = 32'h00000200;
      dw(IDX_MBS_HIGH, 8'h80);
      wait_irq();
      dr(IDX_IRQ_STATUS);
      `CHK("end flag", 8'h02, r[7:0])
      apb(1'b0, OFS_DMA_COUNT, 32'h0);
      `CHK("tail count", 32'd10, r)
      dr(IDX_BC_LOW);
      `CHK("byte count", 8'd50, r[7:0])
      dw(IDX_IRQ_STATUS, 8'h03);
      dw(IDX_MBS_LOW, 8'd40);
      send(40);
      repeat (50) @(posedge i_clk);
      apb(1'b0, OFS_STATUS, 32'h0);
      `CHK("halted", 32'h0, r)
      for (int t = 0; t < 4; t++)
      begin
         dw(IDX_CFG3_HIGH, 8'(t));
         dw(IDX_IRQ_STATUS, 8'h03);
         apb(1'b1, OFS_DMA_BASE, 32'h300);
         exp_addr = 32'h00000300;
         dw(IDX_MBS_HIGH, 8'hc0);
         wait_irq();
         apb(1'b0, OFS_DMA_COUNT, 32'h0);
         `CHK("unlimited count", 32'd40, r)
         dr(IDX_IRQ_STATUS);
         `CHK("no full flag", 8'h02, r[7:0])
         if (t < 3)
            send(40);
      end
      dw(IDX_IRQ_MASK, 8'h00);
      repeat (4) @(posedge i_clk);
      `CHK("masked irq", 1'b0, irq)
      `CHK("leftover", 0, exp_q.size())
      results();
   end
endmodule
`default_nettype wire
